// File: spi_host_command_port.sv
`default_nettype none
module spi_host_command_port
    import spi_host_pkg::*;
(
    // System clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Serial link from the master.
    input wire logic i_sclk,
    input wire logic i_chip_select_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    output logic o_miso_pulldown,
    // Configuration, oscillator status and FIFO read data.
    input wire logic i_sdo_pulldown_1,
    input wire logic i_sdo_pulldown_2,
    input wire logic i_osc_stable,
    input wire logic [7:0] i_fifo_rd_data,
    // Events towards the rest of the chip.
    output logic o_evt_valid,
    output logic [2:0] o_evt_kind,
    output logic o_evt_bank_b,
    output logic [5:0] o_evt_addr,
    output logic [7:0] o_evt_data
);
    typedef struct packed {
        link_phase_t phase;
        logic [2:0] bitcnt;
        logic [6:0] sh;
        logic [5:0] addr;
        logic bank_b;
        logic cmd_pend;
        logic [5:0] cmd_code;
        logic ev_tog;
        logic ev_slot;
        logic [EV_W-1:0] ev_w0;
        logic [EV_W-1:0] ev_w1;
    } link_state_t;

    typedef struct packed {
        logic tog_seen;
        logic sel;
        logic cs_seen;
        logic cmd_wait;
        logic valid;
        logic [2:0] kind;
        logic bank_b;
        logic [5:0] addr;
        logic [7:0] data;
        logic pd;
    } sys_state_t;

    link_state_t lk_reg;
    link_state_t lk_next;
    link_state_t cur;
    sys_state_t sy_reg;
    sys_state_t sy_next;
    logic [7:0] regs_a [64];
    logic [7:0] regs_b [64];
    logic [7:0] store [48];
    logic link_rst;
    logic sclk_n;
    logic in_txn;
    logic osc_s;
    logic osc_ok;
    logic [7:0] fifo_s;
    logic [7:0] byte_in;
    logic done;
    logic reg_we;
    logic store_we;
    logic post;
    logic [EV_W-1:0] post_w;
    logic [7:0] load_data;
    logic drive;
    logic tog_s;
    logic pend_s;
    logic cs_s;
    logic oe_s;
    logic [EV_W-1:0] slot_w;
    logic [5:0] chk_addr_reg;
    logic chk_bank_reg;
    logic [7:0] view_now;
    logic [7:0] view_prev;

    // Select high holds the frame logic in reset, so a partial byte never survives.
    assign link_rst = i_rst | i_chip_select_n;
    assign sclk_n = ~i_sclk;

    always_ff @(negedge i_sclk or posedge link_rst) begin
        if (link_rst) begin
            in_txn <= 1'b0;
        end else begin
            in_txn <= 1'b1;
        end
    end

    // The FIFO byte is only quasi-static here; the chip must hold it while a read runs.
    sync_2ff #(.W(9)) u_link_sync (
        .i_clk(sclk_n),
        .i_rst(i_rst),
        .i_d({i_osc_stable, i_fifo_rd_data}),
        .o_q({osc_s, fifo_s})
    );

    assign osc_ok = regs_a[REG_OP_CTRL][OSC_RUN_BIT] & osc_s;

    always_comb begin
        cur = lk_reg;
        if (!in_txn) begin
            cur.phase = ST_MODE;
            cur.bitcnt = 3'h0;
            cur.bank_b = 1'b0;
            cur.cmd_pend = 1'b0;
        end
        byte_in = {cur.sh, i_mosi};
        done = (cur.bitcnt == 3'h7);
        lk_next = cur;
        lk_next.bitcnt = cur.bitcnt + 3'h1;
        lk_next.sh = byte_in[6:0];
        reg_we = 1'b0;
        store_we = 1'b0;
        post = 1'b0;
        post_w = '0;
        if (done) begin
            case (cur.phase)
                ST_MODE: begin
                    if (byte_in == BANK_SWITCH_BYTE) begin
                        lk_next.bank_b = 1'b1;
                    end else begin
                        if (cur.cmd_pend) begin
                            post = 1'b1;
                            post_w = {EV_CMD, 1'b0, cur.cmd_code, 8'h00};
                            lk_next.cmd_pend = 1'b0;
                        end
                        lk_next.addr = byte_in[5:0];
                        case (byte_in[7:6])
                            MODE_REG_WR: lk_next.phase = ST_REG_WR;
                            MODE_REG_RD: lk_next.phase = ST_REG_RD;
                            MODE_SPECIAL: begin
                                lk_next.phase = osc_ok ? special_phase(byte_in[5:0]) : ST_IGNORE;
                                lk_next.addr = store_base(byte_in[5:0]);
                            end
                            default: begin
                                if (cmd_allowed(byte_in[5:0], osc_ok)) begin
                                    lk_next.cmd_pend = 1'b1;
                                    lk_next.cmd_code = byte_in[5:0];
                                end
                            end
                        endcase
                    end
                end
                ST_REG_WR: begin
                    reg_we = reg_writable(cur.bank_b, cur.addr);
                    post = reg_we;
                    post_w = {EV_REG_WR, cur.bank_b, cur.addr, byte_in};
                    lk_next.addr = cur.addr + 6'h01;
                end
                ST_REG_RD: lk_next.addr = cur.addr + 6'h01;
                ST_FIFO_LD: begin
                    post = 1'b1;
                    post_w = {EV_FIFO_WR, 1'b0, 6'h00, byte_in};
                end
                ST_FIFO_RD: begin
                    post = 1'b1;
                    post_w = {EV_FIFO_RD, 1'b0, 6'h00, 8'h00};
                end
                ST_STORE_LD: begin
                    store_we = (cur.addr <= STORE_LAST);
                    lk_next.addr = cur.addr + 6'h01;
                end
                ST_STORE_RD: lk_next.addr = cur.addr + 6'h01;
                default: ;
            endcase
        end
        // Two slots alternate so a word stays put for two bytes while the other side reads it.
        if (post) begin
            lk_next.ev_tog = ~cur.ev_tog;
            lk_next.ev_slot = ~cur.ev_slot;
            if (cur.ev_slot) begin
                lk_next.ev_w1 = post_w;
            end else begin
                lk_next.ev_w0 = post_w;
            end
        end
    end

    always_ff @(negedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            lk_reg <= '0;
        end else begin
            lk_reg <= lk_next;
        end
    end

    always_ff @(negedge i_sclk) begin
        if (reg_we && cur.bank_b) begin
            regs_b[cur.addr] <= byte_in;
        end else if (reg_we) begin
            regs_a[cur.addr] <= byte_in;
        end
        if (store_we) begin
            store[cur.addr] <= byte_in;
        end
        chk_addr_reg <= cur.addr;
        chk_bank_reg <= cur.bank_b;
    end

    assign view_now = cur.bank_b ? regs_b[cur.addr] : regs_a[cur.addr];
    assign view_prev = chk_bank_reg ? regs_b[chk_addr_reg] : regs_a[chk_addr_reg];

    always_comb begin
        load_data = REG_RESET;
        case (lk_reg.phase)
            ST_REG_RD: begin
                if (reg_present(lk_reg.bank_b, lk_reg.addr)) begin
                    load_data = lk_reg.bank_b ? regs_b[lk_reg.addr] : regs_a[lk_reg.addr];
                end
            end
            ST_FIFO_RD: load_data = fifo_s;
            ST_STORE_RD: begin
                if (lk_reg.addr <= STORE_LAST) begin
                    load_data = store[lk_reg.addr];
                end
            end
            default: load_data = REG_RESET;
        endcase
    end

    assign drive = in_txn && (lk_reg.phase == ST_REG_RD || lk_reg.phase == ST_FIFO_RD
        || lk_reg.phase == ST_STORE_RD);

    spi_sdo_driver u_sdo (
        .i_sclk(i_sclk),
        .i_cs_rst(link_rst),
        .i_drive(drive),
        .i_bit(lk_reg.bitcnt),
        .i_data(load_data),
        .o_sdo(o_miso),
        .o_sdo_oe(o_miso_oe)
    );

    sync_2ff #(.W(4)) u_sys_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d({lk_reg.ev_tog, lk_reg.cmd_pend, i_chip_select_n, o_miso_oe}),
        .o_q({tog_s, pend_s, cs_s, oe_s})
    );

    assign slot_w = sy_reg.sel ? lk_reg.ev_w1 : lk_reg.ev_w0;

    always_comb begin
        sy_next = sy_reg;
        sy_next.valid = 1'b0;
        sy_next.pd = (i_sdo_pulldown_1 | i_sdo_pulldown_2) & ~oe_s;
        sy_next.cs_seen = cs_s;
        if (tog_s != sy_reg.tog_seen) begin
            sy_next.tog_seen = tog_s;
            sy_next.sel = ~sy_reg.sel;
            sy_next.valid = 1'b1;
            {sy_next.kind, sy_next.bank_b, sy_next.addr, sy_next.data} = slot_w;
        end else if (sy_reg.cmd_wait) begin
            sy_next.cmd_wait = 1'b0;
            sy_next.valid = 1'b1;
            sy_next.kind = EV_CMD;
            sy_next.bank_b = 1'b0;
            sy_next.addr = lk_reg.cmd_code;
            sy_next.data = 8'h00;
        end
        if (cs_s && !sy_reg.cs_seen && pend_s) begin
            sy_next.cmd_wait = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sy_reg <= '0;
        end else begin
            sy_reg <= sy_next;
        end
    end

    assign o_evt_valid = sy_reg.valid;
    assign o_evt_kind = sy_reg.kind;
    assign o_evt_bank_b = sy_reg.bank_b;
    assign o_evt_addr = sy_reg.addr;
    assign o_evt_data = sy_reg.data;
    assign o_miso_pulldown = sy_reg.pd;

    AST_MODE_DECODE: assert property (@(negedge i_sclk) disable iff (link_rst)
        (done && cur.phase == ST_MODE && byte_in[7:6] == MODE_REG_RD)
        |=> (lk_reg.phase == ST_REG_RD && lk_reg.addr == $past(byte_in[5:0])))
        else $error("register read mode byte not decoded");
    AST_ADDR_STEP: assert property (@(negedge i_sclk) disable iff (link_rst)
        (done && (cur.phase == ST_REG_WR || cur.phase == ST_REG_RD
        || cur.phase == ST_STORE_LD || cur.phase == ST_STORE_RD))
        |=> (lk_reg.addr == $past(cur.addr) + 6'h01))
        else $error("address did not step by one");
    AST_GATE_SPECIAL: assert property (@(negedge i_sclk) disable iff (link_rst)
        (done && cur.phase == ST_MODE && byte_in[7:6] == MODE_SPECIAL && !osc_ok)
        |=> (lk_reg.phase == ST_IGNORE))
        else $error("FIFO or store access taken without oscillator");
    AST_CMD_GATE: assert property (@(negedge i_sclk) disable iff (link_rst)
        (done && cur.phase == ST_MODE && byte_in[7:6] == MODE_CMD
        && byte_in != BANK_SWITCH_BYTE && !cmd_allowed(byte_in[5:0], osc_ok))
        |=> !lk_reg.cmd_pend)
        else $error("gated command accepted");
    AST_BANK_B: assert property (@(negedge i_sclk) disable iff (link_rst)
        (done && cur.phase == ST_MODE && byte_in == BANK_SWITCH_BYTE)
        |=> (lk_reg.bank_b && lk_reg.phase == ST_MODE))
        else $error("bank prefix not taken");
    AST_TRAILER_UNKNOWN: assert property (@(negedge i_sclk) disable iff (link_rst)
        (done && cur.phase == ST_MODE && byte_in[7:6] == MODE_SPECIAL
        && special_phase(byte_in[5:0]) == ST_IGNORE) |=> (lk_reg.phase == ST_IGNORE))
        else $error("unknown trailer not ignored");
    AST_WRITE_COMMIT: assert property (@(negedge i_sclk) disable iff (link_rst)
        (done && cur.phase == ST_REG_WR && reg_writable(cur.bank_b, cur.addr))
        |=> (view_prev == $past(byte_in)))
        else $error("register byte not committed at last bit");
    AST_WRITE_BLOCKED: assert property (@(negedge i_sclk) disable iff (link_rst)
        (done && cur.phase == ST_REG_WR && !reg_writable(cur.bank_b, cur.addr))
        |=> (view_prev == $past(view_now)))
        else $error("read-only register was changed");
    AST_PULLDOWN: assert property (@(posedge i_clk) disable iff (i_rst)
        (!$past(i_rst) && (i_sdo_pulldown_1 || i_sdo_pulldown_2) && !oe_s) |=> o_miso_pulldown)
        else $error("pull-down missing while released");
    AST_CMD_AT_RELEASE: assert property (@(posedge i_clk) disable iff (i_rst)
        ($rose(cs_s) && pend_s) |-> ##[1:4] (o_evt_valid && o_evt_kind == EV_CMD))
        else $error("command not issued after select release");

    COV_REG_WRITE: cover property (@(posedge i_clk) o_evt_valid && o_evt_kind == EV_REG_WR);
    COV_FIFO_LOAD: cover property (@(posedge i_clk) o_evt_valid && o_evt_kind == EV_FIFO_WR);
    COV_CMD: cover property (@(posedge i_clk) o_evt_valid && o_evt_kind == EV_CMD);
    COV_READ_BURST: cover property (@(negedge i_sclk) disable iff (link_rst)
        done && cur.phase == ST_REG_RD ##8 done && cur.phase == ST_REG_RD);
endmodule
`default_nettype wire

// File: spi_host_command_port_tb_top.sv
`default_nettype none
module spi_host_command_port_tb_top import spi_host_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic pd1 = 1'h0;
    logic pd2 = 1'h1;
    logic osc = 1'h0;
    logic [7:0] fifo_rd = 8'h5A;
    wire logic sclk, chip_select_n, mosi, miso_wire;
    logic miso, oe, pd, ev_valid, ev_bank;
    logic [2:0] ev_kind;
    logic [5:0] ev_addr;
    logic [7:0] ev_data, r1, r2;
    logic [EV_W-1:0] evq[$];
    logic [7:0] rxq[$];
    logic [7:0] b[$];
    int errors = 0;
    int tests_run = 0;
    // A released line shows the pull-down, or else the inverse of its last bit.
    assign miso_wire = oe ? miso : (pd ? 1'h0 : ~miso);
    initial begin
        forever #50 clk = ~clk;
    end
    spi_master_model u_master (.o_sclk(sclk), .o_chip_select_n(chip_select_n),
        .o_mosi(mosi), .i_miso(miso_wire));
    spi_host_command_port DUT (.i_clk(clk), .i_rst(rst), .i_sclk(sclk),
        .i_chip_select_n(chip_select_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe),
        .o_miso_pulldown(pd), .i_sdo_pulldown_1(pd1), .i_sdo_pulldown_2(pd2),
        .i_osc_stable(osc), .i_fifo_rd_data(fifo_rd), .o_evt_valid(ev_valid),
        .o_evt_kind(ev_kind), .o_evt_bank_b(ev_bank), .o_evt_addr(ev_addr),
        .o_evt_data(ev_data));
    always @(posedge clk) begin
        if (ev_valid === 1'h1) begin
            evq.push_back({ev_kind, ev_bank, ev_addr, ev_data});
        end
    end
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_evt(input logic [2:0] k, input logic bk, input logic [5:0] a,
                             input logic [7:0] d);
        logic [EV_W-1:0] e;
        e = '1;
        if (evq.size() > 0) begin
            e = evq.pop_front();
        end
        check8({5'h00, e[17:15]}, {5'h00, k}, "event kind");
        check8(e[7:0], d, "event data");
        if (k == EV_REG_WR || k == EV_CMD) begin
            check8({2'h0, e[13:8]}, {2'h0, a}, "event addr");
        end
        if (k == EV_REG_WR) begin
            check8({7'h00, e[14]}, {7'h00, bk}, "event bank");
        end
    endtask
    task automatic expect_count(input int n);
        for (int k = 0; k < 40 && evq.size() < n; k++) begin
            @(posedge clk);
        end
        repeat (10) @(posedge clk);
        check8(8'(evq.size()), 8'(n), "event count");
        if (evq.size() < n) begin
            end_of_test();
        end
    endtask
    task automatic run(input logic [7:0] q[$]);
        logic [7:0] r;
        rxq.delete();
        u_master.sel();
        foreach (q[i]) begin
            u_master.xfer(q[i], 8, r);
            rxq.push_back(r);
        end
        u_master.desel();
    endtask
    task automatic pins(input logic e_oe, input logic e_pd);
        repeat (6) @(posedge clk);
        check8({7'h00, oe}, {7'h00, e_oe}, "miso enable");
        check8({7'h00, pd}, {7'h00, e_pd}, "pull-down");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        for (int k = 0; k < 3; k++) begin
            pd1 <= (k == 1);
            pd2 <= (k == 0);
            pins(1'h0, k < 2);
        end
        $display("test idle pins done");
        run('{8'h05, 8'hA5, 8'hA6});
        expect_count(2);
        check_evt(EV_REG_WR, 1'h0, 6'h05, 8'hA5);
        check_evt(EV_REG_WR, 1'h0, 6'h06, 8'hA6);
        run('{8'h30, 8'h77});
        run('{8'hFB, 8'h30, 8'h77});
        expect_count(0);
        $display("test register write done");
        pd1 <= 1'h1;
        u_master.gap = 0;
        u_master.sel();
        u_master.xfer(8'h45, 8, r1);
        u_master.xfer(8'h00, 8, r1);
        pins(1'h1, 1'h0);
        u_master.xfer(8'h00, 8, r2);
        u_master.desel();
        check8(r1, 8'hA5, "read first");
        check8(r2, 8'hA6, "read next");
        pins(1'h0, 1'h1);
        run('{8'hFB, 8'h70, 8'h00});
        check8(rxq[2], 8'h00, "absent reg");
        $display("test register read done");
        u_master.gap = 200;
        run('{8'hFB, 8'h05, 8'h3C});
        expect_count(1);
        check_evt(EV_REG_WR, 1'h1, 6'h05, 8'h3C);
        run('{8'hFB, 8'h45, 8'h00});
        check8(rxq[2], 8'h3C, "bank b read");
        run('{8'h45, 8'h00});
        check8(rxq[1], 8'hA5, "bank a after rise");
        $display("test alternate bank done");
        run('{8'hE5});
        run('{8'h80, 8'h12});
        expect_count(0);
        run('{8'hC3, 8'h07, 8'h11});
        expect_count(2);
        check_evt(EV_CMD, 1'h0, 6'h03, 8'h00);
        check_evt(EV_REG_WR, 1'h0, 6'h07, 8'h11);
        $display("test commands done");
        run('{8'h02, 8'h00});
        @(posedge clk) osc <= 1'h1;
        run('{8'h80, 8'h12});
        run('{8'h02, 8'h80});
        expect_count(2);
        check_evt(EV_REG_WR, 1'h0, REG_OP_CTRL, 8'h00);
        check_evt(EV_REG_WR, 1'h0, REG_OP_CTRL, 8'h80);
        run('{8'h80, 8'h12, 8'h34});
        expect_count(2);
        check_evt(EV_FIFO_WR, 1'h0, 6'h00, 8'h12);
        check_evt(EV_FIFO_WR, 1'h0, 6'h00, 8'h34);
        run('{8'hE5});
        run('{8'h9F, 8'h00});
        expect_count(2);
        check_evt(EV_CMD, 1'h0, 6'h25, 8'h00);
        check_evt(EV_FIFO_RD, 1'h0, 6'h00, 8'h00);
        check8(rxq[1], 8'h5A, "fifo read");
        $display("test fifo done");
        // Fill the whole store first so the long read never streams unknown bytes.
        b = '{8'hA0};
        for (int i = 0; i < 48; i++) begin
            b.push_back(8'h00);
        end
        run(b);
        run('{8'hA0, 8'h11, 8'h12});
        run('{8'hA8, 8'h22});
        run('{8'hAC, 8'h33});
        run('{8'h81, 8'h99});
        expect_count(0);
        b = '{8'hBF};
        for (int i = 0; i < 37; i++) begin
            b.push_back(8'h00);
        end
        run(b);
        check8(rxq[1], 8'h11, "store 0");
        check8(rxq[2], 8'h12, "store 1");
        check8(rxq[16], 8'h22, "store 15");
        check8(rxq[37], 8'h33, "store 36");
        $display("test store done");
        u_master.sel();
        u_master.xfer(8'h00, 4, r1);
        u_master.desel();
        run('{8'h09, 8'h5C});
        expect_count(1);
        check_evt(EV_REG_WR, 1'h0, 6'h09, 8'h5C);
        $display("test abort done");
        end_of_test();
    end
endmodule
`default_nettype wire

// File: spi_host_pkg.sv
// Contract
// - Serial port uses clock polarity 0, clock phase 1, select active low.
// - Data in sampled on falling clock edge; data out updated on rising edge.
// - Transfers are whole bytes, most significant bit first both ways.
// - Data out is released whenever there is nothing to send.
// - Released data out gets a pull-down when either pull-down option is set.
// - First byte after select falls: top two bits mode, low six bits trailer.
// - Each further data byte addresses the location one above the previous.
// - Register access always allowed; FIFO and store need oscillator run and stable.
// - Some commands always accepted; others need oscillator run and stable.
// - Mode 00 writes, mode 01 reads registers; trailer holds the address.
// - Mode 10 trailer 000000 loads FIFO, trailer 011111 reads FIFO.
// - Mode 10 trailers 100000, 101000, 101100 load store from 0, 15, 36.
// - Mode 10 trailer 111111 reads the store from location 0.
// - A written byte is committed on the falling edge of its last bit.
// - Writes to absent or read-only registers change nothing.
// - Register read keeps sending successive bytes while clocks continue.
// - Reading an absent register returns zero.
// - Prefix byte FBh selects the alternate bank until select rises.
// - Mode 11 is a one-byte command that starts when select rises.
// - An immediate command may be chained to another mode byte.
`default_nettype none
package spi_host_pkg;
    localparam logic [1:0] MODE_REG_WR = 2'h0;
    localparam logic [1:0] MODE_REG_RD = 2'h1;
    localparam logic [1:0] MODE_SPECIAL = 2'h2;
    localparam logic [1:0] MODE_CMD = 2'h3;
    localparam logic [5:0] TRL_FIFO_LD = 6'h00;
    localparam logic [5:0] TRL_FIFO_RD = 6'h1F;
    localparam logic [5:0] TRL_STORE_A = 6'h20;
    localparam logic [5:0] TRL_STORE_F = 6'h28;
    localparam logic [5:0] TRL_STORE_SLOT = 6'h2C;
    localparam logic [5:0] TRL_STORE_RD = 6'h3F;
    localparam logic [5:0] STORE_F_BASE = 6'h0F;
    localparam logic [5:0] STORE_SLOT_BASE = 6'h24;
    localparam logic [5:0] STORE_LAST = 6'h2F;
    localparam logic [7:0] BANK_SWITCH_BYTE = 8'hFB;
    localparam logic [5:0] REG_OP_CTRL = 6'h02;
    localparam int OSC_RUN_BIT = 7;
    localparam logic [5:0] REG_A_RO_FIRST = 6'h30;
    localparam logic [5:0] REG_B_LAST = 6'h2F;
    localparam logic [5:0] CMD_OSC_FIRST = 6'h20;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] EV_REG_WR = 3'h1;
    localparam logic [2:0] EV_FIFO_WR = 3'h2;
    localparam logic [2:0] EV_FIFO_RD = 3'h3;
    localparam logic [2:0] EV_CMD = 3'h5;
    localparam int EV_W = 18;

    typedef enum logic [2:0] {
        ST_MODE = 3'b000,
        ST_REG_WR = 3'b001,
        ST_REG_RD = 3'b010,
        ST_FIFO_LD = 3'b011,
        ST_FIFO_RD = 3'b100,
        ST_STORE_LD = 3'b101,
        ST_STORE_RD = 3'b110,
        ST_IGNORE = 3'b111
    } link_phase_t;

    function automatic logic reg_present(input logic bank_b, input logic [5:0] a);
        return bank_b ? (a <= REG_B_LAST) : 1'b1;
    endfunction

    function automatic logic reg_writable(input logic bank_b, input logic [5:0] a);
        return reg_present(bank_b, a) && (bank_b || a < REG_A_RO_FIRST);
    endfunction

    function automatic link_phase_t special_phase(input logic [5:0] t);
        case (t)
            TRL_FIFO_LD: return ST_FIFO_LD;
            TRL_FIFO_RD: return ST_FIFO_RD;
            TRL_STORE_A, TRL_STORE_F, TRL_STORE_SLOT: return ST_STORE_LD;
            TRL_STORE_RD: return ST_STORE_RD;
            default: return ST_IGNORE;
        endcase
    endfunction

    function automatic logic [5:0] store_base(input logic [5:0] t);
        if (t == TRL_STORE_F) begin
            return STORE_F_BASE;
        end else if (t == TRL_STORE_SLOT) begin
            return STORE_SLOT_BASE;
        end
        return 6'h00;
    endfunction

    function automatic logic cmd_allowed(input logic [5:0] code, input logic osc_ok);
        return (code < CMD_OSC_FIRST) || osc_ok;
    endfunction
endpackage
`default_nettype wire

// File: spi_master_model.sv
`default_nettype none
module spi_master_model (
    // Serial link towards the device.
    output logic o_sclk,
    output logic o_chip_select_n,
    output logic o_mosi,
    input wire logic i_miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pause between bytes; the serial clock stands still meanwhile.
    int gap = 200;
    initial begin
        o_sclk = 1'h0;
        o_chip_select_n = 1'h1;
        o_mosi = 1'h0;
    end
    task automatic sel();
        #7 o_chip_select_n = 1'h0;
        #16;
    endtask
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            o_sclk = 1'h1;
            o_mosi = tx[i];
            #16 rx[i] = i_miso;
            o_sclk = 1'h0;
            #16;
        end
        // A held data line would let a stale bit pass for a fresh one.
        o_mosi = ~o_mosi;
        #(gap);
    endtask
    task automatic desel();
        o_chip_select_n = 1'h1;
        #500;
    endtask
endmodule
`default_nettype wire

// File: spi_sdo_driver.sv
`default_nettype none
module spi_sdo_driver (
    // Link clock and select-driven reset.
    input wire logic i_sclk,
    input wire logic i_cs_rst,
    // Byte to send and bit position.
    input wire logic i_drive,
    input wire logic [2:0] i_bit,
    input wire logic [7:0] i_data,
    // Data out pin.
    output logic o_sdo,
    output logic o_sdo_oe
);
    typedef struct packed {
        logic [6:0] sh;
        logic sdo;
        logic oe;
    } sdo_state_t;

    sdo_state_t sdo_reg;
    sdo_state_t sdo_next;

    always_comb begin
        sdo_next = sdo_reg;
        sdo_next.oe = i_drive;
        if (i_drive) begin
            if (i_bit == 3'h0) begin
                {sdo_next.sdo, sdo_next.sh} = i_data;
            end else begin
                sdo_next.sdo = sdo_reg.sh[6];
                sdo_next.sh = {sdo_reg.sh[5:0], 1'b0};
            end
        end
    end

    // Rising edge updates the pin so it is settled for the master's falling edge.
    always_ff @(posedge i_sclk or posedge i_cs_rst) begin
        if (i_cs_rst) begin
            sdo_reg <= '0;
        end else begin
            sdo_reg <= sdo_next;
        end
    end

    assign o_sdo = sdo_reg.sdo;
    assign o_sdo_oe = sdo_reg.oe;

    AST_SDO_MSB_FIRST: assert property (@(posedge i_sclk) disable iff (i_cs_rst)
        (i_drive && i_bit == 3'h0) ##1 i_drive |=> (o_sdo == $past(i_data[6], 2)))
        else $error("second bit out is not data bit six");
    AST_SDO_RELEASE: assert property (@(posedge i_sclk) disable iff (i_cs_rst)
        o_sdo_oe |-> $past(i_drive))
        else $error("data out driven without data to send");
endmodule
`default_nettype wire

// File: sync_2ff.sv
`default_nettype none
module sync_2ff #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Levels from another domain.
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= '0;
            o_q <= '0;
        end else begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule
`default_nettype wire
